// *** rtl/pdc_reset_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

module pdc_reset_ctrl #(
  parameter int STARTUP_CYCLES = pdc_pkg::STARTUP_CYCLES,
  parameter int SEQ_CYCLES = pdc_pkg::RESET_SEQ_CYCLES,
  parameter int FILTER_CYCLES = pdc_pkg::DEGLITCH_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic hw_reset_n_pin,
  input wire logic link_state_pin,
  input wire logic indicator_pin_zero,
  input wire logic gp_clock_125_select,
  input wire logic reference_clock_cfg_enable,
  input wire logic gp_clock_cfg_enable,
  input wire logic [15:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic mgmt_write,
  input wire logic mgmt_read,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_ack,
  output logic mgmt_refused,
  output logic [1:0] strap_values,
  output logic oscillator_enable,
  output logic clock_multiplier_enable,
  output logic clock_multiplier_reset,
  output logic slow_clock_select,
  output logic reference_clock_out_enable,
  output logic general_purpose_clock_out_enable,
  output logic subsys_regs_reset,
  output logic core_regs_reset,
  output logic transceiver_core_reset,
  output logic mac_interface_reset,
  output logic mac_out_enable,
  output logic mac_force_idle,
  output logic line_receive_enable,
  output logic link_bringup_start,
  output logic autoneg_start
);

  localparam int CW = $clog2(STARTUP_CYCLES + 1);
  ////////////////////////////////////////////////////////////////////////////////
  // Pins
  logic hw_level;
  logic [1:0] strap_s1;
  logic [1:0] strap_s2;
  pdc_pin_filter #(
    .CYCLES(FILTER_CYCLES)
  ) u_reset_filter (
    .clock(clock),
    .reset(reset),
    .pin(hw_reset_n_pin),
    .level(hw_level)
  );

  always_ff @(posedge clock) begin
    strap_s1 <= {link_state_pin, indicator_pin_zero};
    strap_s2 <= strap_s1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  pdc_pkg::pdc_state_t state;
  pdc_pkg::pdc_state_t next_state;
  logic [CW-1:0] count;
  logic [15:0] core_control;
  logic relatch_enable;
  logic relatch_active;
  logic [1:0] latched_strap;
  logic accessible;
  logic soft_pd;
  logic line_active;
  logic wr_core_reset;
  logic wr_subsys_reset;
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] target);
    return addr == target;
  endfunction
  assign soft_pd = core_control[pdc_pkg::SOFT_PD_POS];
  assign accessible = (state != pdc_pkg::ST_HW_PD) && (state != pdc_pkg::ST_STARTUP);
  assign line_active = (state == pdc_pkg::ST_RUN) && !soft_pd;
  assign wr_subsys_reset = mgmt_write && hit(mgmt_addr, pdc_pkg::REG_SUBSYS_RESET)
                           && mgmt_wdata[pdc_pkg::SUBSYS_RESET_POS];
  assign wr_core_reset = mgmt_write && hit(mgmt_addr, pdc_pkg::REG_CORE_CONTROL)
                         && mgmt_wdata[pdc_pkg::CORE_RESET_POS];
  always_comb begin
    next_state = state;
    if (!hw_level) begin
      next_state = pdc_pkg::ST_HW_PD;
    end else begin
      unique case (state)
        pdc_pkg::ST_HW_PD: begin
          next_state = pdc_pkg::ST_STARTUP;
        end
        pdc_pkg::ST_STARTUP: begin
          if (count == CW'(STARTUP_CYCLES - 1)) begin
            next_state = pdc_pkg::ST_RUN;
          end
        end
        pdc_pkg::ST_RUN: begin
          if (wr_subsys_reset) begin
            next_state = pdc_pkg::ST_SUBSYS;
          end else if (wr_core_reset) begin
            next_state = pdc_pkg::ST_CORE;
          end
        end
        pdc_pkg::ST_SUBSYS, pdc_pkg::ST_CORE: begin
          if (count == CW'(SEQ_CYCLES - 1)) begin
            next_state = pdc_pkg::ST_RUN;
          end
        end
        default: begin
          next_state = pdc_pkg::ST_HW_PD;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= pdc_pkg::ST_HW_PD;
      count <= '0;
    end else begin
      state <= next_state;
      count <= (next_state != state) ? '0 : count + CW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Straps: sampled only on leaving hardware reset or on a relatch reset
  always_ff @(posedge clock) begin
    if (reset) begin
      latched_strap <= pdc_pkg::STRAP_RESET;
    end else if (state == pdc_pkg::ST_HW_PD && hw_level) begin
      latched_strap <= strap_s2;
    end else if (state == pdc_pkg::ST_RUN && wr_subsys_reset && relatch_enable) begin
      latched_strap <= strap_s2;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      relatch_active <= 1'b0;
    end else if (state == pdc_pkg::ST_RUN) begin
      relatch_active <= wr_subsys_reset && relatch_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clock) begin
    if (reset) begin
      core_control <= pdc_pkg::CORE_CONTROL_RESET;
    end else if (state != pdc_pkg::ST_RUN) begin
      // Defaults rebuilt from the held strap copy; the pins are not looked at
      core_control <= pdc_pkg::CORE_CONTROL_RESET;
      core_control[pdc_pkg::SOFT_PD_POS] <= pdc_pkg::strap_soft_pd(latched_strap);
    end else if (mgmt_write && hit(mgmt_addr, pdc_pkg::REG_CORE_CONTROL) && !wr_core_reset) begin
      core_control <= mgmt_wdata;
      core_control[pdc_pkg::CORE_RESET_POS] <= 1'b0;
    end
  end

  // Subsystem register: survives a core reset, cleared by any subsystem reset
  always_ff @(posedge clock) begin
    if (reset) begin
      relatch_enable <= 1'b0;
    end else if (state == pdc_pkg::ST_HW_PD || state == pdc_pkg::ST_SUBSYS) begin
      relatch_enable <= 1'b0;
    end else if (state == pdc_pkg::ST_RUN && mgmt_write
                 && hit(mgmt_addr, pdc_pkg::REG_SUBSYS_RESET_CFG)) begin
      relatch_enable <= mgmt_wdata[pdc_pkg::RELATCH_POS];
    end
  end

  // Writes during a reset sequence are acknowledged but dropped
  always_ff @(posedge clock) begin
    if (reset) begin
      mgmt_rdata <= 16'h0000;
      mgmt_ack <= 1'b0;
      mgmt_refused <= 1'b0;
    end else begin
      mgmt_ack <= (mgmt_read || mgmt_write) && accessible;
      mgmt_refused <= (mgmt_read || mgmt_write) && !accessible;
      if (mgmt_read && accessible) begin
        mgmt_rdata <= 16'h0000;
        if (hit(mgmt_addr, pdc_pkg::REG_CORE_CONTROL)) begin
          mgmt_rdata <= core_control;
          mgmt_rdata[pdc_pkg::CORE_RESET_POS] <= state == pdc_pkg::ST_CORE;
        end else if (hit(mgmt_addr, pdc_pkg::REG_SUBSYS_RESET)) begin
          mgmt_rdata[pdc_pkg::SUBSYS_RESET_POS] <= state == pdc_pkg::ST_SUBSYS;
        end else if (hit(mgmt_addr, pdc_pkg::REG_SUBSYS_RESET_CFG)) begin
          mgmt_rdata[pdc_pkg::RELATCH_POS] <= relatch_enable;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, one cycle behind the state
  always_ff @(posedge clock) begin
    if (reset) begin
      oscillator_enable <= 1'b0;
      clock_multiplier_enable <= 1'b0;
      clock_multiplier_reset <= 1'b1;
      slow_clock_select <= 1'b0;
      reference_clock_out_enable <= 1'b0;
      general_purpose_clock_out_enable <= 1'b0;
      subsys_regs_reset <= 1'b1;
      core_regs_reset <= 1'b1;
      transceiver_core_reset <= 1'b1;
      mac_interface_reset <= 1'b1;
      mac_out_enable <= 1'b0;
      mac_force_idle <= 1'b1;
      line_receive_enable <= 1'b0;
      link_bringup_start <= 1'b0;
      autoneg_start <= 1'b0;
      strap_values <= pdc_pkg::STRAP_RESET;
    end else begin
      oscillator_enable <= state != pdc_pkg::ST_HW_PD;
      // Multiplier idles in hardware power-down, and in soft power-down only when nothing needs 125 MHz
      clock_multiplier_enable <= state != pdc_pkg::ST_HW_PD
                                 && !(state == pdc_pkg::ST_RUN && soft_pd
                                      && !gp_clock_125_select);
      clock_multiplier_reset <= state == pdc_pkg::ST_HW_PD || state == pdc_pkg::ST_STARTUP
                                || ((state == pdc_pkg::ST_SUBSYS || state == pdc_pkg::ST_CORE)
                                    && !gp_clock_125_select);
      slow_clock_select <= state == pdc_pkg::ST_RUN && soft_pd;
      reference_clock_out_enable <= reference_clock_cfg_enable
                                    && (state == pdc_pkg::ST_RUN || state == pdc_pkg::ST_CORE
                                        || (state == pdc_pkg::ST_SUBSYS && !relatch_active));
      general_purpose_clock_out_enable <= gp_clock_cfg_enable
                                    && (state == pdc_pkg::ST_RUN || state == pdc_pkg::ST_CORE
                                        || (state == pdc_pkg::ST_SUBSYS && !relatch_active));
      subsys_regs_reset <= !accessible || state == pdc_pkg::ST_SUBSYS;
      core_regs_reset <= state != pdc_pkg::ST_RUN;
      transceiver_core_reset <= state != pdc_pkg::ST_RUN;
      mac_interface_reset <= !accessible || state == pdc_pkg::ST_SUBSYS;
      mac_out_enable <= state != pdc_pkg::ST_HW_PD;
      mac_force_idle <= !line_active;
      line_receive_enable <= line_active;
      link_bringup_start <= line_active && !line_receive_enable;
      autoneg_start <= line_active && !line_receive_enable
                       && core_control[pdc_pkg::AUTONEG_POS];
      strap_values <= latched_strap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int SEQ_BOUND = SEQ_CYCLES + 2;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  property p_hwpd_tristate;
    !hw_level |-> ##2 (!mac_out_enable && !oscillator_enable && !clock_multiplier_enable);
  endproperty
  a_hwpd_tristate: assert property (p_hwpd_tristate) else $error("hw pd outputs");
  property p_hwpd_clocks;
    !hw_level |-> ##2 (!reference_clock_out_enable && !general_purpose_clock_out_enable);
  endproperty
  a_hwpd_clocks: assert property (p_hwpd_clocks) else $error("hw pd clock out");
  property p_hwpd_refuse;
    (state == pdc_pkg::ST_HW_PD && (mgmt_read || mgmt_write)) |=> (mgmt_refused && !mgmt_ack);
  endproperty
  a_hwpd_refuse: assert property (p_hwpd_refuse) else $error("access not refused");
  property p_subsys_resets;
    $rose(state == pdc_pkg::ST_SUBSYS) |=> (mac_interface_reset && transceiver_core_reset
                                           && subsys_regs_reset && core_regs_reset);
  endproperty
  a_subsys_resets: assert property (p_subsys_resets) else $error("subsys reset scope");
  property p_core_spares;
    state == pdc_pkg::ST_CORE |=> (!mac_interface_reset && !subsys_regs_reset
                                   && $stable(relatch_enable));
  endproperty
  a_core_spares: assert property (p_core_spares) else $error("core reset too wide");
  property p_no_resample;
    (state == pdc_pkg::ST_CORE || (state == pdc_pkg::ST_SUBSYS && !relatch_active))
      |=> $stable(latched_strap);
  endproperty
  a_no_resample: assert property (p_no_resample) else $error("straps resampled");
  property p_cmu_skip;
    ((state == pdc_pkg::ST_CORE || state == pdc_pkg::ST_SUBSYS) && gp_clock_125_select)
      |=> !clock_multiplier_reset;
  endproperty
  a_cmu_skip: assert property (p_cmu_skip) else $error("multiplier reset at 125");
  property p_clock_keep;
    (state == pdc_pkg::ST_CORE && reference_clock_cfg_enable && hw_level)
      |=> (reference_clock_out_enable && oscillator_enable);
  endproperty
  a_clock_keep: assert property (p_clock_keep) else $error("ref clock stopped");
  property p_core_self_clear;
    $rose(state == pdc_pkg::ST_CORE) |-> ##[1:SEQ_BOUND] (state != pdc_pkg::ST_CORE);
  endproperty
  a_core_self_clear: assert property (p_core_self_clear) else $error("core reset stuck");
  property p_pd_idle;
    (state == pdc_pkg::ST_RUN && soft_pd)
      |=> (mac_force_idle && !line_receive_enable && slow_clock_select);
  endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("power-down not idle");
  property p_strap_default;
    state == pdc_pkg::ST_STARTUP |=> soft_pd == pdc_pkg::strap_soft_pd(latched_strap);
  endproperty
  a_strap_default: assert property (p_strap_default) else $error("pd default wrong");
  property p_bringup;
    ($fell(soft_pd) && state == pdc_pkg::ST_RUN) |=> (link_bringup_start ##1 !link_bringup_start);
  endproperty
  a_bringup: assert property (p_bringup) else $error("no bring-up pulse");
  c_relatch: cover property (state == pdc_pkg::ST_SUBSYS && relatch_active);
  c_core: cover property ($fell(state == pdc_pkg::ST_CORE));
  c_pd_exit: cover property (link_bringup_start && autoneg_start);
  c_hw_pd: cover property ($rose(state == pdc_pkg::ST_HW_PD));

endmodule

`default_nettype wire

// *** rtl/pdc_pkg.sv ***
package pdc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [15:0] REG_CORE_CONTROL = 16'h0000;
  localparam logic [15:0] REG_SUBSYS_RESET = 16'hff0c;
  localparam logic [15:0] REG_SUBSYS_RESET_CFG = 16'hff0d;

  localparam int CORE_RESET_POS = 15;
  localparam int AUTONEG_POS = 12;
  localparam int SOFT_PD_POS = 11;
  localparam int SUBSYS_RESET_POS = 0;
  localparam int RELATCH_POS = 0;

  // Soft power-down bit is overlaid from the straps
  localparam logic [15:0] CORE_CONTROL_RESET = 16'h1000;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLOCK_MHZ = 50;
  localparam int RESET_SEQ_NS = 1000;
  localparam int RESET_SEQ_CYCLES = (RESET_SEQ_NS * CLOCK_MHZ + 999) / 1000;
  localparam int DEGLITCH_NS = 1000;
  localparam int DEGLITCH_CYCLES = (DEGLITCH_NS * CLOCK_MHZ + 999) / 1000;
  localparam int STARTUP_US = 5000;
  localparam int STARTUP_CYCLES = STARTUP_US * CLOCK_MHZ;

  ////////////////////////////////////////////////////////////////////////////////
  // Straps and states
  localparam logic [1:0] STRAP_PD_CODE = 2'h3;
  localparam logic [1:0] STRAP_RESET = 2'h0;

  typedef enum logic [4:0] {
    ST_HW_PD = 5'h01,
    ST_STARTUP = 5'h02,
    ST_RUN = 5'h04,
    ST_SUBSYS = 5'h08,
    ST_CORE = 5'h10
  } pdc_state_t;

  function automatic logic strap_soft_pd(input logic [1:0] straps);
    return straps == STRAP_PD_CODE;
  endfunction

endpackage

// *** rtl/pdc_pin_filter.sv ***
`timescale 1ns/1ps
`default_nettype none

module pdc_pin_filter #(
  parameter int CYCLES = pdc_pkg::DEGLITCH_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic pin,
  output logic level
);

  localparam int CW = $clog2(CYCLES + 1);

  logic sync1;
  logic sync2;
  logic [CW-1:0] count;

  always_ff @(posedge clock) begin
    sync1 <= pin;
    sync2 <= sync1;
  end

  // Level only moves after the synced pin has differed for CYCLES clocks
  always_ff @(posedge clock) begin
    if (reset) begin
      count <= '0;
      level <= 1'b0;
    end else if (sync2 == level) begin
      count <= '0;
    end else if (count == CW'(CYCLES - 1)) begin
      count <= '0;
      level <= sync2;
    end else begin
      count <= count + CW'(1);
    end
  end

endmodule

`default_nettype wire

// *** tb/pdc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module pdc_host_model (
  input wire logic clock,
  input wire logic mgmt_ack,
  input wire logic mgmt_refused,
  input wire logic [15:0] mgmt_rdata,
  output logic hw_reset_n_pin,
  output logic [15:0] mgmt_addr,
  output logic [15:0] mgmt_wdata,
  output logic mgmt_write,
  output logic mgmt_read
);
  initial begin
    hw_reset_n_pin = 1'b1;
    mgmt_addr = 16'h0000;
    mgmt_wdata = 16'h0000;
    mgmt_write = 1'b0;
    mgmt_read = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Long holds are the caller's duty; short pulses only probe the deglitch
  task automatic set_reset_pin(input logic level);
    @(posedge clock);
    #1;
    hw_reset_n_pin = level;
  endtask

  // Strobe stands one cycle; address and data are inverted afterwards so late sampling shows
  task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data,
                        output logic [15:0] rdata, output logic ack, output logic refused);
    @(posedge clock);
    #1;
    mgmt_addr = addr;
    mgmt_wdata = data;
    mgmt_write = wr;
    mgmt_read = !wr;
    @(posedge clock);
    #1;
    mgmt_write = 1'b0;
    mgmt_read = 1'b0;
    mgmt_addr = ~addr;
    mgmt_wdata = ~data;
    // Ack and refused stand only until the next edge, so take them now
    rdata = mgmt_rdata;
    ack = mgmt_ack;
    refused = mgmt_refused;
    @(posedge clock);
    #1;
  endtask
endmodule

`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic link_state_pin = 1'b1;
  logic indicator_pin_zero = 1'b1;
  logic gp_clock_125_select = 1'b0;
  logic reference_clock_cfg_enable = 1'b1;
  logic gp_clock_cfg_enable = 1'b1;
  logic hw_reset_n_pin, mgmt_write, mgmt_read, mgmt_ack, mgmt_refused, ack, refused;
  logic [15:0] mgmt_addr, mgmt_wdata, mgmt_rdata, rd_data;
  logic [1:0] strap_values;
  logic oscillator_enable, clock_multiplier_enable, clock_multiplier_reset, slow_clock_select;
  logic reference_clock_out_enable, general_purpose_clock_out_enable, subsys_regs_reset;
  logic core_regs_reset, transceiver_core_reset, mac_interface_reset, mac_out_enable;
  logic mac_force_idle, line_receive_enable, link_bringup_start, autoneg_start;
  int n_fail = 0;
  int tests_run = 0;
  int exp_core;
  int data_q[$];

  always #10 clock = ~clock;

  pdc_reset_ctrl #(.STARTUP_CYCLES(20), .SEQ_CYCLES(4), .FILTER_CYCLES(4)) u_pdc_reset_ctrl (
    .clock, .reset, .hw_reset_n_pin, .link_state_pin, .indicator_pin_zero,
    .gp_clock_125_select, .reference_clock_cfg_enable, .gp_clock_cfg_enable,
    .mgmt_addr, .mgmt_wdata, .mgmt_write, .mgmt_read, .mgmt_rdata, .mgmt_ack, .mgmt_refused,
    .strap_values, .oscillator_enable, .clock_multiplier_enable, .clock_multiplier_reset,
    .slow_clock_select, .reference_clock_out_enable, .general_purpose_clock_out_enable,
    .subsys_regs_reset, .core_regs_reset, .transceiver_core_reset, .mac_interface_reset,
    .mac_out_enable, .mac_force_idle, .line_receive_enable, .link_bringup_start, .autoneg_start
  );

  pdc_host_model u_pdc_host_model (
    .clock, .mgmt_ack, .mgmt_refused, .mgmt_rdata, .hw_reset_n_pin,
    .mgmt_addr, .mgmt_wdata, .mgmt_write, .mgmt_read
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    check(name, {15'h0000, exp}, {15'h0000, got});
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    u_pdc_host_model.access(1'b1, addr, data, rd_data, ack, refused);
    check_bit("write ack", 1'b1, ack);
  endtask

  task automatic rd(input logic [15:0] addr);
    u_pdc_host_model.access(1'b0, addr, 16'h0000, rd_data, ack, refused);
    check_bit("read ack", 1'b1, ack);
  endtask

  // Polls instead of a fixed delay, so a slow startup is still bounded
  task automatic wait_ready();
    ack = 1'b0;
    for (int i = 0; i < 100 && ack !== 1'b1; i++) begin
      u_pdc_host_model.access(1'b0, 16'h0000, 16'h0000, rd_data, ack, refused);
    end
    check_bit("ready", 1'b1, ack);
  endtask

  task automatic wait_seq_end();
    for (int i = 0; i < 40 && (transceiver_core_reset | subsys_regs_reset) !== 1'b0; i++) begin
      step(1);
    end
    check_bit("sequence end", 1'b0, transceiver_core_reset);
  endtask

  task automatic pd_checks(input logic pd, input logic mult);
    check_bit("slow clock", pd, slow_clock_select);
    check_bit("multiplier", mult, clock_multiplier_enable);
    check_bit("idle", pd, mac_force_idle);
    check_bit("line", !pd, line_receive_enable);
    check_bit("ref clock", 1'b1, reference_clock_out_enable);
    check_bit("gp clock", 1'b1, general_purpose_clock_out_enable);
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    $display("[FAIL] watchdog expected finish seen timeout");
    final_report();
  end

  initial begin
    void'($urandom(35139));
    step(5);
    check_bit("tristate", 1'b0, mac_out_enable);
    check_bit("ref off", 1'b0, reference_clock_out_enable);
    check_bit("gp off", 1'b0, general_purpose_clock_out_enable);
    check_bit("multiplier off", 1'b0, clock_multiplier_enable);
    reset = 1'b0;
    u_pdc_host_model.access(1'b0, 16'h0000, 16'h0000, rd_data, ack, refused);
    check_bit("early refused", 1'b1, refused);
    wait_ready();
    exp_core = 32'h1800;
    rd(16'h0000);
    check("core control", exp_core[15:0], rd_data);
    pd_checks(1'b1, 1'b0);
    for (int g = 0; g < 2; g++) begin
      gp_clock_125_select = g[0];
      wr(16'h0000, 16'h1800);
      step(1);
      pd_checks(1'b1, g[0]);
      rd(16'h0000);
      check("pd read", 16'h1800, rd_data);
      wr(16'h0000, g[0] ? 16'h0000 : 16'h1000);
      // The pulse stands between the first and second edge after the write
      check_bit("bringup", 1'b1, link_bringup_start);
      check_bit("autoneg", !g[0], autoneg_start);
      step(1);
      check_bit("bringup pulse", 1'b0, link_bringup_start);
      pd_checks(1'b0, 1'b1);
    end
    repeat (4) data_q.push_back($urandom & 32'h77ff);
    while (data_q.size() > 0) begin
      exp_core = data_q.pop_front();
      wr(16'h0000, exp_core[15:0]);
      rd(16'h0000);
      check("plain bits", exp_core[15:0], rd_data);
    end
    link_state_pin = 1'b0;
    for (int k = 0; k < 4; k++) begin
      gp_clock_125_select = k[0];
      reference_clock_cfg_enable = (k != 1);
      gp_clock_cfg_enable = (k != 2);
      if (k < 2) wr(16'h0000, 16'h8000);
      else wr(16'hff0c, 16'h0001);
      step(1);
      check_bit("core reset", 1'b1, transceiver_core_reset);
      check_bit("core regs", 1'b1, core_regs_reset);
      check_bit("mac reset", k[1], mac_interface_reset);
      check_bit("subsys regs", k[1], subsys_regs_reset);
      check_bit("mult reset", !k[0], clock_multiplier_reset);
      check_bit("osc", 1'b1, oscillator_enable);
      check_bit("ref run", reference_clock_cfg_enable, reference_clock_out_enable);
      check_bit("gp run", gp_clock_cfg_enable, general_purpose_clock_out_enable);
      rd(k[1] ? 16'hff0c : 16'h0000);
      check_bit("busy", 1'b1, k[1] ? rd_data[0] : rd_data[15]);
      wait_seq_end();
      check("straps kept", 16'h0003, {14'h0000, strap_values});
      rd(16'hff0c);
      check("subsys clear", 16'h0000, rd_data);
      rd(16'h0000);
      check("core default", 16'h1800, rd_data);
    end
    gp_clock_125_select = 1'b0;
    indicator_pin_zero = 1'b0;
    wr(16'hff0d, 16'h0001);
    rd(16'hff0d);
    check("relatch set", 16'h0001, rd_data);
    wr(16'hff0c, 16'h0001);
    step(1);
    check_bit("ref stopped", 1'b0, reference_clock_out_enable);
    check_bit("gp stopped", 1'b0, general_purpose_clock_out_enable);
    check_bit("mac relatch", 1'b1, mac_interface_reset);
    check_bit("osc relatch", 1'b1, oscillator_enable);
    wait_seq_end();
    check("straps new", 16'h0000, {14'h0000, strap_values});
    rd(16'hff0d);
    check("relatch clear", 16'h0000, rd_data);
    rd(16'h0000);
    check("core new default", 16'h1000, rd_data);
    wr(16'h0005, 16'hffff);
    rd(16'h0005);
    check("unmapped", 16'h0000, rd_data);
    u_pdc_host_model.set_reset_pin(1'b0);
    u_pdc_host_model.set_reset_pin(1'b1);
    step(12);
    check_bit("glitch ignored", 1'b1, mac_out_enable);
    u_pdc_host_model.set_reset_pin(1'b0);
    step(500);
    check_bit("hw tristate", 1'b0, mac_out_enable);
    check_bit("hw ref", 1'b0, reference_clock_out_enable);
    check_bit("hw gp", 1'b0, general_purpose_clock_out_enable);
    check_bit("hw multiplier", 1'b0, clock_multiplier_enable);
    u_pdc_host_model.access(1'b0, 16'h0000, 16'h0000, rd_data, ack, refused);
    check_bit("hw refused", 1'b1, refused);
    u_pdc_host_model.set_reset_pin(1'b1);
    wait_ready();
    check_bit("outputs back", 1'b1, mac_out_enable);
    final_report();
  end
endmodule

`default_nettype wire
